/* common/wdt_defines.vh */
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// Edge polarity select codes.
`define POL_RISE          2'h0
`define POL_FALL          2'h1
`define POL_BOTH          2'h2

// Cycle counts of the two capacitor sequences.
`define TIMEOUT_CYCLES    6'h20
`define RESET_CYCLES      3'h4
`define CYC_CNT_W         6

// Standby time after a deep supply dip, in ns, and the clock period in ns.
`define STANDBY_NS        20000
`define CLK_PERIOD_NS     50
`define STANDBY_CYCLES    (`STANDBY_NS / `CLK_PERIOD_NS)
`define STANDBY_W         10

`endif

/* hw/pin_sync.v */
`timescale 1ns/1ps
module pin_sync (
    input  wire sys_clk_i,
    input  wire rst_i,
    input  wire ce_i,
    input  wire pin_i,
    output reg  level_o
);
    reg stage1;
    reg stage2;
    reg stage3;

    // The first stage feeds only the second; a change counts once stages two and three agree.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            stage1  <= 1'b0;
            stage2  <= 1'b0;
            stage3  <= 1'b0;
            level_o <= 1'b0;
        end else if (ce_i) begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level_o <= stage3;
            end
        end
    end
endmodule

/* hw/window_watchdog_edge_control.v */
`timescale 1ns/1ps
`include "wdt_defines.vh"

// Contract
// - Counter clears on rising, falling or both edges of kick_input, by option.
// - Window mode: second edge inside early window drives fault output low.
// - Enable high-low-high after an edge cancels the early-window double check.
// - Both-edge mode flags double pulse only for rising then falling.
// - Both-edge mode, falling then rising: no fault, counter still cleared.
// - Enable falling while cycling stops and discharges the timeout capacitor.
// - Enable falling also clears the timeout cycle count.
// - Enable returning high restarts timeout cycling from zero.
// - After low voltage, reset delay counts only after its discharge completes.
// - After double pulse, next timeout cycling waits for discharge completion.
// - Deep supply dip needs 20 us standby before initialization may start.
// - Short dip still reruns full reset-delay sequence before timeout counting.
// - 32 timeout cycles without qualifying edge drive fault output low.
// - Reset and fault outputs release only after 4 reset-delay cycles.
// - Qualifying edge clears count, discharges, resumes after discharge done.
module window_watchdog_edge_control (
    input  wire       sys_clk_i,
    input  wire       rst_i,
    input  wire       ce_i,
    input  wire       kick_input_i,
    input  wire       enable_i,
    input  wire       window_mode_i,
    input  wire [1:0] edge_polarity_i,
    input  wire       low_voltage_i,
    input  wire       deep_dip_i,
    input  wire       supply_dip_i,
    input  wire       timeout_cycle_tick_i,
    input  wire       timeout_discharged_i,
    input  wire       reset_cycle_tick_i,
    input  wire       reset_discharged_i,
    output reg        fault_output_n_o,
    output reg        reset_output_n_o,
    output reg        timeout_cycling_o,
    output reg        timeout_discharge_o,
    output reg        reset_cycling_o,
    output reg        reset_discharge_o,
    output reg        double_pulse_o,
    output reg        timeout_fault_o
);
    localparam [2:0] ST_STANDBY  = 3'h0;
    localparam [2:0] ST_RDISCH   = 3'h1;
    localparam [2:0] ST_RCOUNT   = 3'h2;
    localparam [2:0] ST_IDLE     = 3'h3;
    localparam [2:0] ST_TCYCLE   = 3'h4;
    localparam [2:0] ST_TDISCH   = 3'h5;
    localparam [2:0] ST_FAULT    = 3'h6;

    localparam [31:0]           STANDBY_SPAN = `STANDBY_CYCLES - 1;
    localparam [`STANDBY_W-1:0] STANDBY_LAST = STANDBY_SPAN[`STANDBY_W-1:0];

    reg  [2:0]            state;
    reg  [`CYC_CNT_W-1:0] tcount;
    reg  [2:0]            rcount;
    reg  [`STANDBY_W-1:0] standby_cnt;
    reg                   kick_prev;
    reg                   en_prev;
    reg                   window_open;
    reg                   window_rise;
    reg                   deep_seen;

    wire kick_lvl;
    wire en_lvl;

    pin_sync u_kick_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .pin_i     (kick_input_i),
        .level_o   (kick_lvl)
    );

    pin_sync u_en_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .pin_i     (enable_i),
        .level_o   (en_lvl)
    );

    wire rise_edge = kick_lvl & ~kick_prev;
    wire fall_edge = ~kick_lvl & kick_prev;
    wire en_fall   = ~en_lvl & en_prev;

    wire qual_edge = (edge_polarity_i == `POL_RISE) ? rise_edge :
                     (edge_polarity_i == `POL_FALL) ? fall_edge :
                     (rise_edge | fall_edge);

    // both-edge doubles need rise then fall
    wire double_hit = window_mode_i & window_open & qual_edge &
                      ((edge_polarity_i != `POL_BOTH) | (window_rise & fall_edge));

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            state               <= ST_STANDBY;
            tcount              <= {`CYC_CNT_W{1'b0}};
            rcount              <= 3'h0;
            standby_cnt         <= {`STANDBY_W{1'b0}};
            kick_prev           <= 1'b0;
            en_prev             <= 1'b0;
            window_open         <= 1'b0;
            window_rise         <= 1'b0;
            deep_seen           <= 1'b0;
            fault_output_n_o    <= 1'b0;
            reset_output_n_o    <= 1'b0;
            timeout_cycling_o   <= 1'b0;
            timeout_discharge_o <= 1'b0;
            reset_cycling_o     <= 1'b0;
            reset_discharge_o   <= 1'b0;
            double_pulse_o      <= 1'b0;
            timeout_fault_o     <= 1'b0;
        end else if (ce_i) begin
            kick_prev       <= kick_lvl;
            en_prev         <= en_lvl;
            double_pulse_o  <= 1'b0;
            timeout_fault_o <= 1'b0;
            if (low_voltage_i | supply_dip_i) begin
                // any dip reruns the full reset-delay sequence.
                state               <= ST_STANDBY;
                deep_seen           <= deep_dip_i;
                // standby during dip
                // A long deep dip has used up its standby by the time supply returns.
                if (deep_dip_i & deep_seen) begin
                    if (standby_cnt < STANDBY_LAST) begin
                        standby_cnt <= standby_cnt + 1'b1;
                    end
                end else if (deep_dip_i) begin
                    standby_cnt <= {`STANDBY_W{1'b0}};
                end else if (state != ST_STANDBY) begin
                    standby_cnt <= STANDBY_LAST;
                end
                rcount              <= 3'h0;
                tcount              <= {`CYC_CNT_W{1'b0}};
                window_open         <= 1'b0;
                fault_output_n_o    <= ~low_voltage_i & fault_output_n_o;
                reset_output_n_o    <= ~low_voltage_i & reset_output_n_o;
                timeout_cycling_o   <= 1'b0;
                timeout_discharge_o <= 1'b1;
                reset_cycling_o     <= 1'b0;
                reset_discharge_o   <= 1'b1;
            end else begin
                deep_seen <= 1'b0;
                case (state)
                    ST_STANDBY: begin
                        if (standby_cnt >= STANDBY_LAST) begin
                            state <= ST_RDISCH;
                        end else begin
                            standby_cnt <= standby_cnt + 1'b1;
                        end
                    end
                    ST_RDISCH: begin
                        // reset delay waits for its discharge
                        if (reset_discharged_i | ~reset_discharge_o) begin
                            reset_discharge_o <= 1'b0;
                            reset_cycling_o   <= 1'b1;
                            rcount            <= 3'h0;
                            state             <= ST_RCOUNT;
                        end
                    end
                    ST_RCOUNT: begin
                        if (reset_cycle_tick_i) begin
                            if (rcount + 3'h1 >= `RESET_CYCLES) begin
                                reset_cycling_o  <= 1'b0;
                                fault_output_n_o <= 1'b1;
                                reset_output_n_o <= 1'b1;
                                state            <= ST_IDLE;
                            end else begin
                                rcount <= rcount + 3'h1;
                            end
                        end
                    end
                    ST_IDLE: begin
                        // no restart until timeout discharge done
                        if (timeout_discharged_i) begin
                            timeout_discharge_o <= 1'b0;
                        end
                        if (en_lvl & (~timeout_discharge_o | timeout_discharged_i)) begin
                            tcount            <= {`CYC_CNT_W{1'b0}};
                            timeout_cycling_o <= 1'b1;
                            state             <= ST_TCYCLE;
                        end
                    end
                    ST_TCYCLE: begin
                        if (en_fall) begin
                            timeout_cycling_o   <= 1'b0;
                            timeout_discharge_o <= 1'b1;
                            tcount              <= {`CYC_CNT_W{1'b0}};
                            // enable toggle cancels the window check
                            window_open         <= 1'b0;
                            state               <= ST_IDLE;
                        end else if (double_hit) begin
                            double_pulse_o      <= 1'b1;
                            fault_output_n_o    <= 1'b0;
                            timeout_cycling_o   <= 1'b0;
                            timeout_discharge_o <= 1'b1;
                            window_open         <= 1'b0;
                            reset_cycling_o     <= 1'b1;
                            rcount              <= 3'h0;
                            state               <= ST_FAULT;
                        end else if (qual_edge) begin
                            tcount              <= {`CYC_CNT_W{1'b0}};
                            timeout_cycling_o   <= 1'b0;
                            timeout_discharge_o <= 1'b1;
                            window_open         <= 1'b1;
                            window_rise         <= rise_edge;
                            state               <= ST_TDISCH;
                        end else if (timeout_cycle_tick_i) begin
                            if (window_open) begin
                                // The early window ends after one full cycle.
                                window_open <= 1'b0;
                            end
                            if (tcount + 1'b1 >= `TIMEOUT_CYCLES) begin
                                timeout_fault_o     <= 1'b1;
                                fault_output_n_o    <= 1'b0;
                                timeout_cycling_o   <= 1'b0;
                                timeout_discharge_o <= 1'b1;
                                reset_cycling_o     <= 1'b1;
                                rcount              <= 3'h0;
                                state               <= ST_FAULT;
                            end else begin
                                tcount <= tcount + 1'b1;
                            end
                        end
                    end
                    ST_TDISCH: begin
                        if (en_fall) begin
                            window_open <= 1'b0;
                            state       <= ST_IDLE;
                        end else if (double_hit) begin
                            double_pulse_o   <= 1'b1;
                            fault_output_n_o <= 1'b0;
                            window_open      <= 1'b0;
                            reset_cycling_o  <= 1'b1;
                            rcount           <= 3'h0;
                            state            <= ST_FAULT;
                        end else if (qual_edge) begin
                            window_rise <= rise_edge;
                        end else if (timeout_discharged_i) begin
                            timeout_discharge_o <= 1'b0;
                            timeout_cycling_o   <= 1'b1;
                            state               <= ST_TCYCLE;
                        end
                    end
                    ST_FAULT: begin
                        if (timeout_discharged_i) begin
                            timeout_discharge_o <= 1'b0;
                        end
                        if (reset_cycle_tick_i) begin
                            if (rcount + 3'h1 >= `RESET_CYCLES) begin
                                reset_cycling_o  <= 1'b0;
                                fault_output_n_o <= 1'b1;
                                state            <= ST_IDLE;
                            end else begin
                                rcount <= rcount + 3'h1;
                            end
                        end
                    end
                    default: begin
                        state <= ST_STANDBY;
                    end
                endcase
            end
        end
    end
endmodule

/* verification/wdt_checker_assertions.sv */
`timescale 1ns/1ps
module wdt_checker (
    input wire sys_clk_i,
    input wire rst_i,
    input wire enable_i,
    input wire window_mode_i,
    input wire low_voltage_i,
    input wire reset_cycle_tick_i,
    input wire timeout_discharged_i,
    input wire reset_discharged_i,
    input wire fault_output_n_o,
    input wire reset_output_n_o,
    input wire timeout_cycling_o,
    input wire timeout_discharge_o,
    input wire reset_cycling_o,
    input wire double_pulse_o,
    input wire timeout_fault_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    property p_tmo; timeout_fault_o |-> !fault_output_n_o; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout without fault");
    property p_dbl; double_pulse_o |-> !fault_output_n_o && reset_cycling_o && window_mode_i;
    endproperty
    a_dbl: assert property (p_dbl) else $error("double pulse bad");
    property p_rel;
        $rose(reset_output_n_o) |-> $past(reset_cycle_tick_i) || $past(reset_cycle_tick_i, 2);
    endproperty
    a_rel: assert property (p_rel) else $error("release not after tick");
    property p_enf; $fell(enable_i) && timeout_cycling_o && !low_voltage_i
        |-> ##[2:6] (timeout_discharge_o && !timeout_cycling_o); endproperty
    a_enf: assert property (p_enf) else $error("enable fall no discharge");
    property p_res; $rose(timeout_cycling_o) |-> $past(timeout_discharged_i); endproperty
    a_res: assert property (p_res) else $error("cycling before discharge");
    property p_hold; $fell(fault_output_n_o) && reset_output_n_o
        |=> (!fault_output_n_o) [*8]; endproperty
    a_hold: assert property (p_hold) else $error("fault hold short");
    property p_rst; $rose(reset_cycling_o) && !double_pulse_o && !timeout_fault_o
        |-> $past(reset_discharged_i); endproperty
    a_rst: assert property (p_rst) else $error("reset delay before discharge");
    property p_lv; low_voltage_i |=> !fault_output_n_o && !reset_output_n_o; endproperty
    a_lv: assert property (p_lv) else $error("low voltage outputs high");
endmodule

/* verification/host_kick_model.sv */
`timescale 1ns/1ps
module host_kick_model (
    input  wire sys_clk_i,
    input  wire toggle_i,
    output reg  kick_o
);
    initial kick_o = 1'b0;
    always @(posedge sys_clk_i) begin
        if (toggle_i) begin
            kick_o <= #2 ~kick_o;
        end
    end
endmodule

/* verification/window_watchdog_edge_control_tb.sv */
`timescale 1ns/1ps
`include "wdt_defines.vh"
module window_watchdog_edge_control_tb;
    logic sys_clk_i = 0, rst_i = 1, ce_i = 1, enable_i = 1, window_mode_i = 0, toggle = 0;
    logic [1:0] edge_polarity_i = `POL_BOTH;
    logic low_voltage_i = 0, deep_dip_i = 0, supply_dip_i = 0, got, d;
    logic timeout_cycle_tick_i = 0, timeout_discharged_i = 1;
    logic reset_cycle_tick_i = 0, reset_discharged_i = 1;
    logic [2:0] tcnt = 0, rcnt = 0, tdc = 3'h3, rdc = 3'h3;
    wire kick_input_i, fault_output_n_o, reset_output_n_o, timeout_cycling_o;
    wire timeout_discharge_o, reset_cycling_o, reset_discharge_o, double_pulse_o, timeout_fault_o;
    int err_count = 0, cmp_count = 0, tticks = 0, rticks = 0, i, k;
    window_watchdog_edge_control dut (.*);
    host_kick_model host (.sys_clk_i(sys_clk_i), .toggle_i(toggle), .kick_o(kick_input_i));
    initial forever #25 sys_clk_i = ~sys_clk_i;
    // Both capacitors take 8 clocks a cycle and 3 clocks to discharge.
    always @(posedge sys_clk_i) begin
        if (timeout_cycle_tick_i) tticks++;
        if (reset_cycle_tick_i) rticks++;
        #2;
        tcnt = timeout_cycling_o ? tcnt + 3'h1 : 3'h0;
        rcnt = reset_cycling_o ? rcnt + 3'h1 : 3'h0;
        if (rst_i || timeout_cycling_o) tdc = rst_i ? 3'h3 : 3'h0;
        else if (timeout_discharge_o && tdc != 3'h3) tdc = tdc + 3'h1;
        if (rst_i || reset_cycling_o) rdc = rst_i ? 3'h3 : 3'h0;
        else if (reset_discharge_o && rdc != 3'h3) rdc = rdc + 3'h1;
        timeout_cycle_tick_i = tcnt == 3'h7;
        reset_cycle_tick_i = rcnt == 3'h7;
        timeout_discharged_i = tdc == 3'h3;
        reset_discharged_i = rdc == 3'h3;
    end
    task chk(input string nm, input logic exp, input logic seen);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %b seen %b", nm, exp, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask
    task kick;
        toggle = 1;
        cyc(1);
        toggle = 0;
    endtask
    task t_start;
        cyc(300);
        chk("reset_n early", 1'b0, reset_output_n_o);
        for (i = 0; i < 400 && reset_output_n_o !== 1'b1; i++) cyc(1);
        chk("reset ticks", 1'b1, rticks == 4);
        chk("fault_n", 1'b1, fault_output_n_o);
        cyc(4);
        chk("cycling", 1'b1, timeout_cycling_o);
    endtask
    task t_clear(input logic by_en);
        cyc(160);
        if (by_en) enable_i = 0;
        else kick;
        for (i = 0; i < 20 && timeout_discharge_o !== 1'b1; i++) cyc(1);
        chk("discharge", 1'b1, timeout_discharge_o);
        chk("cycling off", 1'b0, timeout_cycling_o);
        tticks = 0;
        cyc(12);
        chk("held off", !by_en, timeout_cycling_o);
        enable_i = 1;
        for (i = 0; i < 400 && timeout_fault_o !== 1'b1; i++) cyc(1);
        chk("ticks to timeout", 1'b1, tticks == 32);
        chk("fault_n low", 1'b0, fault_output_n_o);
        for (i = 0; i < 100 && fault_output_n_o !== 1'b1; i++) cyc(1);
        chk("fault_n back", 1'b1, fault_output_n_o);
        for (i = 0; i < 20 && timeout_cycling_o !== 1'b1; i++) cyc(1);
        chk("restart", 1'b1, timeout_cycling_o);
    endtask
    task t_dbl(input logic [1:0] pol, input logic lvl, input int n, input logic exp, en);
        window_mode_i = 1;
        edge_polarity_i = pol;
        if (kick_input_i !== lvl) kick;
        cyc(30);
        for (k = 0; k < n; k++) begin
            kick;
            if (en && k == 0) begin
                cyc(1);
                enable_i = 0;
                cyc(6);
                enable_i = 1;
            end else cyc(2);
        end
        got = 0;
        d = 0;
        for (i = 0; i < 12; i++) begin
            got = got | double_pulse_o;
            d = d | timeout_discharge_o;
            cyc(1);
        end
        chk("double pulse", exp, got);
        chk("fault_n", !exp, fault_output_n_o);
        if (!exp) chk("discharge", 1'b1, d);
        cyc(80);
        window_mode_i = 0;
        chk("fault_n after", 1'b1, fault_output_n_o);
        chk("cycling after", 1'b1, timeout_cycling_o);
    endtask
    task t_dip;
        supply_dip_i = 1;
        cyc(1);
        chk("dip discharge", 1'b1, reset_discharge_o);
        supply_dip_i = 0;
        for (i = 0; i < 10 && reset_cycling_o !== 1'b1; i++) cyc(1);
        chk("dip discharge wait", 1'b1, i >= 3);
        chk("dip rerun", 1'b1, reset_cycling_o);
        chk("dip tmo off", 1'b0, timeout_cycling_o);
        chk("dip fault_n", 1'b1, fault_output_n_o);
        for (i = 0; i < 100 && reset_cycling_o !== 1'b0; i++) cyc(1);
        for (i = 0; i < 20 && timeout_cycling_o !== 1'b1; i++) cyc(1);
        chk("dip resume", 1'b1, timeout_cycling_o);
        low_voltage_i = 1;
        deep_dip_i = 1;
        cyc(10);
        chk("lv reset_n", 1'b0, reset_output_n_o);
        low_voltage_i = 0;
        deep_dip_i = 0;
        cyc(300);
        chk("standby", 1'b0, reset_cycling_o);
        for (i = 0; i < 300 && reset_output_n_o !== 1'b1; i++) cyc(1);
        chk("lv release", 1'b1, reset_output_n_o);
    endtask
    task give_verdict;
        $display("errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        err_count++;
        give_verdict;
    end
    initial begin
        cyc(5);
        rst_i = 0;
        t_start;
        t_clear(1'b0);
        t_clear(1'b1);
        t_dbl(`POL_RISE, 1'b0, 3, 1'b1, 1'b0);
        t_dbl(`POL_FALL, 1'b1, 3, 1'b1, 1'b0);
        t_dbl(`POL_BOTH, 1'b0, 2, 1'b1, 1'b0);
        t_dbl(`POL_BOTH, 1'b1, 2, 1'b0, 1'b0);
        t_dbl(`POL_BOTH, 1'b0, 2, 1'b0, 1'b1);
        t_dip;
        give_verdict;
    end
endmodule
bind window_watchdog_edge_control wdt_checker u_chk (.*);
